//--- hdl/dcs_pkg.sv
// Shared constants, register map and state types of the drive control block.
package dcs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CYC_MIN_NS = 250_000;
    localparam int CYC_MIN_CLKS = (CYC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] PERIOD_RST = 16'hC350;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] A_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] A_POSCTL = 6'h04;
    localparam logic [ADDR_W-1:0] A_BLKSEL = 6'h08;
    localparam logic [ADDR_W-1:0] A_MDIMOD = 6'h0C;
    localparam logic [ADDR_W-1:0] A_CONFIG = 6'h10;
    localparam logic [ADDR_W-1:0] A_PERIOD = 6'h14;
    localparam logic [ADDR_W-1:0] A_STAT1 = 6'h18;
    localparam logic [ADDR_W-1:0] A_STAT2 = 6'h1C;
    localparam logic [ADDR_W-1:0] A_INFO = 6'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int C_ON = 0;
    localparam int C_NO_COAST = 1;
    localparam int C_NO_QSTOP = 2;
    localparam int C_ENABLE = 3;
    localparam int S_RDY_ON = 0;
    localparam int S_RDY_OP = 1;
    localparam int S_OP_EN = 2;
    localparam int S_INHIB = 6;
    localparam int S2_PULSE = 11;
    localparam int P_ABS = 8;
    localparam int P_ADJUST = 14;
    localparam int P_DIRECT = 15;
    localparam int B_DIRECT = 15;
    localparam int M_ABS = 0;
    localparam int CF_TG9 = 0;
    localparam int CF_ISO = 1;
    localparam int I_DIRECT = 4;
    localparam int I_ADJUST = 5;
    localparam int I_ABS = 6;
    localparam int I_FAST = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT,
        ST_INHIBITED,
        ST_READY,
        ST_SWITCHED_ON,
        ST_OPERATION,
        ST_RAMP_STOP,
        ST_QUICK_STOP
    } dcs_state_t;

    typedef struct packed {
        logic prev;
        logic armed;
        logic [15:0] cnt;
        logic tick;
        logic too_fast;
    } dcs_timer_st_t;

    typedef struct packed {
        logic direct;
        logic adjust;
        logic absolute;
    } dcs_mode_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] pos;
        logic [15:0] blk;
        logic [15:0] mdim;
        logic tg9;
        logic iso;
        logic [15:0] period;
        dcs_state_t state;
        logic [15:0] stat1;
        logic [15:0] stat2;
        logic too_fast;
        logic wait_req;
        logic [31:0] rdata;
        logic torque;
        logic ramp;
        logic quick;
    } dcs_top_st_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic sel_bit(input logic [15:0] w, input int idx);
        sel_bit = w[idx];
    endfunction : sel_bit

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = old;
        if (be[0])
        begin
            merge16[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            merge16[15:8] = wd[15:8];
        end
    endfunction : merge16

endpackage : dcs_pkg

//--- hdl/dcs_cycle_timer.sv
// Evaluation tick source: isochronous cycle clock or free-running divider.
`timescale 1ns/1ps
module dcs_cycle_timer
    import dcs_pkg::*;
#(
    parameter logic [15:0] MIN_CLKS = 16'(CYC_MIN_CLKS)
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic iso_i,
    input wire logic cycle_clk_i,
    input wire logic [15:0] period_i,
    output logic tick_o,
    output logic too_fast_o
);

    if (MIN_CLKS < 16'h0001)
    begin : g_chk
        $error("MIN_CLKS must be at least one cycle.");
    end

    dcs_timer_st_t q;
    dcs_timer_st_t d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        d.too_fast = 1'b0;
        d.prev = cycle_clk_i;
        if (iso_i)
        begin
            if (q.cnt < MIN_CLKS)
            begin
                d.cnt = q.cnt + 16'h0001;
            end
            // Edges closer than the least period to the last accepted edge are dropped, but the
            // first edge after reset or after free-running mode is taken whatever its distance.
            if (cycle_clk_i && !q.prev)
            begin
                if (!q.armed || q.cnt >= MIN_CLKS - 16'h0001) // RULE1
                begin
                    d.tick = 1'b1;
                    d.cnt = '0;
                    d.armed = 1'b1;
                end
                else
                begin
                    d.too_fast = 1'b1;
                end
            end
        end
        else
        begin
            d.armed = 1'b0;
            if (q.cnt + 16'h0001 >= period_i)
            begin
                d.tick = 1'b1;
                d.cnt = '0;
            end
            else
            begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign tick_o = q.tick;
    assign too_fast_o = q.too_fast;

endmodule : dcs_cycle_timer

//--- hdl/dcs_mode_decoder.sv
// Direct-setpoint mode selection decoder, sampled once per evaluation tick.
`timescale 1ns/1ps
module dcs_mode_decoder
    import dcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic tick_i,
    input wire logic tg9_i,
    input wire logic [15:0] pos_i,
    input wire logic [15:0] blk_i,
    input wire logic [15:0] mdim_i,
    output dcs_mode_t mode_o
);

    dcs_mode_t q;
    dcs_mode_t d;

    always_comb
    begin
        d = q;
        if (tick_i)
        begin
            if (tg9_i)
            begin
                d.direct = sel_bit(blk_i, B_DIRECT); // RULE20
                d.adjust = 1'b0; // RULE21
                d.absolute = sel_bit(mdim_i, M_ABS); // RULE23
            end
            else
            begin
                d.direct = sel_bit(pos_i, P_DIRECT); // RULE19
                d.adjust = sel_bit(pos_i, P_ADJUST); // RULE21
                d.absolute = sel_bit(pos_i, P_ABS); // RULE22
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign mode_o = q;

endmodule : dcs_mode_decoder

//--- hdl/dcs_drive_ctrl.sv
// Drive control state machine with Avalon-MM register slave.
//
// Behaviour
// RULE1 - Isochronous cycle no shorter than 250 us.
// RULE2 - After init enter inhibited without command.
// RULE3 - Inhibited to ready: bit0=0, bit1=1, bit2=1.
// RULE4 - Ready to switched-on when bit0 is 1.
// RULE5 - Bit3 toggles switched-on and operation.
// RULE6 - Switched-on to ready when bit0 clears.
// RULE7 - Ready/switched-on inhibited when bit1 or bit2 low.
// RULE8 - Operation or switching-off: bit1 low inhibits.
// RULE9 - Operation to ramp stop when bit0 clears.
// RULE10 - Operation to quick stop when bit2 clears.
// RULE11 - Ramp stop escalates to quick stop on bit2.
// RULE12 - Ramp stop to ready: bit3 low or stopped.
// RULE13 - Quick stop to inhibited: bit3 low or stopped.
// RULE14 - Inhibited status: bits0-2 zero, bit6 set, no pulse.
// RULE15 - Ready status: bit0 set only, no pulse.
// RULE16 - Switched-on status: bits0,1 set, no pulse.
// RULE17 - Operation status: bits0-2 set, pulse enabled.
// RULE18 - Switching-off status: bits0,1 set, pulse enabled.
// RULE19 - Telegram 111 position bit15 selects direct mode.
// RULE20 - Telegram 9 selection bit15 selects direct mode.
// RULE21 - Telegram 111 bit14 adjustment; telegram 9 positioning.
// RULE22 - Telegram 111 bit8 selects absolute positioning.
// RULE23 - Telegram 9 mode word bit0 selects absolute.
// RULE24 - One evaluation and transition per cycle.
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module dcs_drive_ctrl
    import dcs_pkg::*;
#(
    parameter int MIN_CYCLE_CLKS = CYC_MIN_CLKS
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic network_cycle_clk_i,
    input wire logic decel_done_i,
    output logic [15:0] drive_status_word_one_o,
    output logic [15:0] drive_status_word_two_o,
    output logic torque_enable_o,
    output logic ramp_stop_o,
    output logic quick_stop_o,
    output logic direct_setpoint_mode_o,
    output logic adjustment_mode_o,
    output logic absolute_positioning_o,
    output logic eval_tick_o
);

    if (MIN_CYCLE_CLKS < 1 || MIN_CYCLE_CLKS > 65535)
    begin : g_chk
        $error("MIN_CYCLE_CLKS must lie between 1 and 65535.");
    end

    // ------------------------------------------------------------------
    // Status encoding
    // ------------------------------------------------------------------
    function automatic logic [15:0] enc_stat1(input dcs_state_t s);
        enc_stat1 = '0;
        case (s)
            ST_INIT, ST_INHIBITED:
            begin
                enc_stat1[S_INHIB] = 1'b1; // RULE14
            end
            ST_READY:
            begin
                enc_stat1[S_RDY_ON] = 1'b1; // RULE15
            end
            ST_SWITCHED_ON, ST_RAMP_STOP, ST_QUICK_STOP:
            begin
                enc_stat1[S_RDY_ON] = 1'b1; // RULE16 RULE18
                enc_stat1[S_RDY_OP] = 1'b1;
            end
            ST_OPERATION:
            begin
                enc_stat1[S_RDY_ON] = 1'b1; // RULE17
                enc_stat1[S_RDY_OP] = 1'b1;
                enc_stat1[S_OP_EN] = 1'b1;
            end
            default:
            begin
                enc_stat1[S_INHIB] = 1'b1;
            end
        endcase
    endfunction : enc_stat1

    function automatic logic [15:0] enc_stat2(input dcs_state_t s);
        enc_stat2 = '0;
        case (s)
            ST_OPERATION, ST_RAMP_STOP, ST_QUICK_STOP:
            begin
                enc_stat2[S2_PULSE] = 1'b1; // RULE17 RULE18
            end
            default:
            begin
                enc_stat2[S2_PULSE] = 1'b0; // RULE14 RULE15 RULE16
            end
        endcase
    endfunction : enc_stat2

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    dcs_top_st_t q;
    dcs_top_st_t d;
    logic tick;
    logic too_fast_ev;
    dcs_mode_t mode;

    dcs_cycle_timer #(
        .MIN_CLKS(16'(MIN_CYCLE_CLKS))
    ) u_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .iso_i(q.iso),
        .cycle_clk_i(network_cycle_clk_i),
        .period_i(q.period),
        .tick_o(tick),
        .too_fast_o(too_fast_ev)
    );

    dcs_mode_decoder u_mode (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(tick),
        .tg9_i(q.tg9),
        .pos_i(q.pos),
        .blk_i(q.blk),
        .mdim_i(q.mdim),
        .mode_o(mode)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic req;
    logic take;
    dcs_state_t ns;
    logic on_b;
    logic nocoast_b;
    logic noqs_b;
    logic en_b;

    always_comb
    begin
        d = q;
        req = avs_read_i | avs_write_i;
        take = req & ~q.wait_req;
        on_b = q.ctrl[C_ON];
        nocoast_b = q.ctrl[C_NO_COAST];
        noqs_b = q.ctrl[C_NO_QSTOP];
        en_b = q.ctrl[C_ENABLE];
        ns = q.state;

        // Priority: coast stop, quick stop, ramp stop, then enable.
        case (q.state)
            ST_INIT:
            begin
                ns = ST_INHIBITED; // RULE2
            end
            ST_INHIBITED:
            begin
                if (!on_b && nocoast_b && noqs_b)
                begin
                    ns = ST_READY; // RULE3
                end
            end
            ST_READY:
            begin
                if (!nocoast_b || !noqs_b)
                begin
                    ns = ST_INHIBITED; // RULE7
                end
                else if (on_b)
                begin
                    ns = ST_SWITCHED_ON; // RULE4
                end
            end
            ST_SWITCHED_ON:
            begin
                if (!nocoast_b || !noqs_b)
                begin
                    ns = ST_INHIBITED; // RULE7
                end
                else if (!on_b)
                begin
                    ns = ST_READY; // RULE6
                end
                else if (en_b)
                begin
                    ns = ST_OPERATION; // RULE5
                end
            end
            ST_OPERATION:
            begin
                if (!nocoast_b)
                begin
                    ns = ST_INHIBITED; // RULE8
                end
                else if (!noqs_b)
                begin
                    ns = ST_QUICK_STOP; // RULE10
                end
                else if (!on_b)
                begin
                    ns = ST_RAMP_STOP; // RULE9
                end
                else if (!en_b)
                begin
                    ns = ST_SWITCHED_ON; // RULE5
                end
            end
            ST_RAMP_STOP:
            begin
                if (!nocoast_b)
                begin
                    ns = ST_INHIBITED; // RULE8
                end
                else if (!noqs_b)
                begin
                    ns = ST_QUICK_STOP; // RULE11
                end
                else if (!en_b || decel_done_i)
                begin
                    ns = ST_READY; // RULE12
                end
            end
            ST_QUICK_STOP:
            begin
                if (!nocoast_b || !en_b || decel_done_i)
                begin
                    ns = ST_INHIBITED; // RULE8 RULE13
                end
            end
            default:
            begin
                ns = ST_INHIBITED;
            end
        endcase

        // The leave-init step needs no tick; every other step waits for one.
        if (tick || q.state == ST_INIT) // RULE24
        begin
            d.state = ns;
            d.stat1 = enc_stat1(ns); // RULE24
            d.stat2 = enc_stat2(ns);
            d.torque = (ns == ST_OPERATION); // RULE17
            d.ramp = (ns == ST_RAMP_STOP);
            d.quick = (ns == ST_QUICK_STOP);
        end

        // Bus slave: one wait state, then the request is taken.
        d.wait_req = ~(req & q.wait_req);
        if (req && q.wait_req)
        begin
            d.rdata = '0;
            if (avs_read_i)
            begin
                case (avs_address_i)
                    A_CTRL: d.rdata[15:0] = q.ctrl;
                    A_POSCTL: d.rdata[15:0] = q.pos;
                    A_BLKSEL: d.rdata[15:0] = q.blk;
                    A_MDIMOD: d.rdata[15:0] = q.mdim;
                    A_CONFIG:
                    begin
                        d.rdata[CF_TG9] = q.tg9;
                        d.rdata[CF_ISO] = q.iso;
                    end
                    A_PERIOD: d.rdata[15:0] = q.period;
                    A_STAT1: d.rdata[15:0] = q.stat1;
                    A_STAT2: d.rdata[15:0] = q.stat2;
                    A_INFO:
                    begin
                        d.rdata[2:0] = q.state;
                        d.rdata[I_DIRECT] = mode.direct;
                        d.rdata[I_ADJUST] = mode.adjust;
                        d.rdata[I_ABS] = mode.absolute;
                        d.rdata[I_FAST] = q.too_fast;
                    end
                    default: d.rdata = '0;
                endcase
            end
        end

        if (take && avs_write_i)
        begin
            case (avs_address_i)
                A_CTRL: d.ctrl = merge16(q.ctrl, avs_writedata_i, avs_byteenable_i);
                A_POSCTL: d.pos = merge16(q.pos, avs_writedata_i, avs_byteenable_i);
                A_BLKSEL: d.blk = merge16(q.blk, avs_writedata_i, avs_byteenable_i);
                A_MDIMOD: d.mdim = merge16(q.mdim, avs_writedata_i, avs_byteenable_i);
                A_CONFIG:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        d.tg9 = avs_writedata_i[CF_TG9];
                        d.iso = avs_writedata_i[CF_ISO];
                    end
                end
                A_PERIOD:
                begin
                    d.period = merge16(q.period, avs_writedata_i, avs_byteenable_i);
                end
                A_INFO:
                begin
                    if (avs_byteenable_i[1] && avs_writedata_i[I_FAST])
                    begin
                        d.too_fast = 1'b0;
                    end
                end
                default:
                begin
                    d.too_fast = d.too_fast;
                end
            endcase
        end

        // A rejected cycle edge in the clearing cycle still sets the flag.
        if (too_fast_ev)
        begin
            d.too_fast = 1'b1; // RULE1
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '0;
            q.state <= ST_INIT;
            q.period <= PERIOD_RST;
            q.wait_req <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    logic tick_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= tick;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wait_req;
    assign drive_status_word_one_o = q.stat1;
    assign drive_status_word_two_o = q.stat2;
    assign torque_enable_o = q.torque;
    assign ramp_stop_o = q.ramp;
    assign quick_stop_o = q.quick;
    assign direct_setpoint_mode_o = mode.direct;
    assign adjustment_mode_o = mode.adjust;
    assign absolute_positioning_o = mode.absolute;
    assign eval_tick_o = tick_q;

endmodule : dcs_drive_ctrl

//--- bench/dcs_drive_ctrl_props.sv
// Port checker of the drive control block.
`timescale 1ns/1ps
module dcs_drive_ctrl_props
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] drive_status_word_one_o,
    input wire logic [15:0] drive_status_word_two_o,
    input wire logic torque_enable_o,
    input wire logic ramp_stop_o,
    input wire logic quick_stop_o,
    input wire logic eval_tick_o
);
    // ------------
    // Properties
    // ------------
    wire logic [15:0] s1 = drive_status_word_one_o;
    wire logic [15:0] s2 = drive_status_word_two_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_init;
        $rose(rst_b_i) |=> s1 == 16'h0040 && s2 == 16'h0000;
    endproperty
    a_init: assert property (p_init) else $error("status after reset wrong");
    property p_inhib;
        s1[6] |-> s1[2:0] == 3'b000 && s2[11] == 1'b0;
    endproperty
    a_inhib: assert property (p_inhib) else $error("inhibited status wrong");
    property p_op;
        torque_enable_o |-> s1[6:0] == 7'h07 && s2[11];
    endproperty
    a_op: assert property (p_op) else $error("operation status wrong");
    property p_stop;
        ramp_stop_o || quick_stop_o |-> s1[6:0] == 7'h03 && s2[11];
    endproperty
    a_stop: assert property (p_stop) else $error("stopping status wrong");
    property p_one;
        $past(rst_b_i, 2) && !eval_tick_o |-> $stable(s1) && $stable(s2);
    endproperty
    a_one: assert property (p_one) else $error("status moved without tick");
    property p_wake;
        $past(s1) == 16'h0040 |-> s1 inside {16'h0040, 16'h0001};
    endproperty
    a_wake: assert property (p_wake) else $error("bad exit from inhibited");
    property p_quick;
        $past(quick_stop_o) |-> quick_stop_o || s1 == 16'h0040;
    endproperty
    a_quick: assert property (p_quick) else $error("bad exit from quick stop");
    property p_ramp;
        $past(ramp_stop_o) |-> ramp_stop_o || quick_stop_o || s1 inside {16'h0001, 16'h0040};
    endproperty
    a_ramp: assert property (p_ramp) else $error("bad exit from ramp stop");
    c_op: cover property (torque_enable_o);
    c_ramp: cover property (ramp_stop_o);
    c_quick: cover property (quick_stop_o);
endmodule : dcs_drive_ctrl_props

//--- bench/dcs_plc_model.sv
// Controller model that drives the isochronous cycle clock.
`timescale 1ns/1ps
module dcs_plc_model
#(
    parameter int HALF = 20
)
(
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic fast_i,
    output logic cycle_clk_o
);
    // ------------
    // Cycle clock
    // ------------
    int cnt = 0;
    initial cycle_clk_o = 1'b0;
    // Held low between runs; fast mode breaks the minimum period on purpose.
    always @(posedge clk_i)
    begin
        cnt <= (run_i && cnt < (fast_i ? 2 : HALF - 1)) ? cnt + 1 : 0;
        cycle_clk_o <= run_i ? cycle_clk_o ^ (cnt == 0) : 1'b0;
    end
endmodule : dcs_plc_model

//--- bench/dcs_drive_ctrl_tb_top.sv
// Self-checking testbench of the drive control block.
`timescale 1ns/1ps
module dcs_drive_ctrl_tb_top
    import dcs_pkg::*;
;
    // ------------
    // Stimulus and checks
    // ------------
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = '0;
    logic dd = 1'b0, run = 1'b0, fast = 1'b0;
    logic ncc, wq, tq, rs, qs, dm, am, ab, tk;
    logic [31:0] q, rdata;
    logic [15:0] s1, s2;
    logic [15:0] lf = 16'h0062;
    logic [3:0] corner [16] = '{4'h6, 4'h7, 4'hF, 4'hE, 4'h7, 4'h7, 4'hF, 4'hB,
                                4'hF, 4'h7, 4'h6, 4'h7, 4'hF, 4'hD, 4'h6, 4'h2};
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    dcs_drive_ctrl #(.MIN_CYCLE_CLKS(20)) i_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(q), .avs_waitrequest_o(wq), .network_cycle_clk_i(ncc),
        .decel_done_i(dd), .drive_status_word_one_o(s1), .drive_status_word_two_o(s2),
        .torque_enable_o(tq), .ramp_stop_o(rs), .quick_stop_o(qs),
        .direct_setpoint_mode_o(dm), .adjustment_mode_o(am),
        .absolute_positioning_o(ab), .eval_tick_o(tk));
    dcs_plc_model i_plc (.clk_i(clk_i), .run_i(run), .fast_i(fast), .cycle_clk_o(ncc));

    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : rnd

    function automatic dcs_state_t nxt(dcs_state_t s, logic [3:0] c, logic d);
        case (s)
            ST_INHIBITED: nxt = c[2:0] == 3'b110 ? ST_READY : s;
            ST_READY: nxt = c[2:1] != 2'b11 ? ST_INHIBITED : c[0] ? ST_SWITCHED_ON : s;
            ST_SWITCHED_ON: nxt = c[2:1] != 2'b11 ? ST_INHIBITED : !c[0] ? ST_READY
                : c[3] ? ST_OPERATION : s;
            ST_OPERATION: nxt = !c[1] ? ST_INHIBITED : !c[2] ? ST_QUICK_STOP
                : !c[0] ? ST_RAMP_STOP : !c[3] ? ST_SWITCHED_ON : s;
            ST_RAMP_STOP: nxt = !c[1] ? ST_INHIBITED : !c[2] ? ST_QUICK_STOP
                : (!c[3] || d) ? ST_READY : s;
            ST_QUICK_STOP: nxt = (!c[1] || !c[3] || d) ? ST_INHIBITED : s;
            default: nxt = ST_INHIBITED;
        endcase
    endfunction : nxt

    function automatic logic [15:0] sw1(dcs_state_t s);
        case (s)
            ST_INHIBITED: return 16'h0040;
            ST_READY: return 16'h0001;
            ST_OPERATION: return 16'h0007;
            default: return 16'h0003;
        endcase
    endfunction : sw1

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        adr <= a;
        wd <= {16'h0000, d};
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wq !== 1'b0);
        rdata = q;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    initial forever #10 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            err_count++;
            wrap_up();
        end
    end

    initial
    begin
        dcs_state_t st;
        logic [15:0] r, p, b, m;
        logic [3:0] c;
        logic d, ed, ea, eb;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        bus(0, A_STAT1, 0);
        chk("stat1", rdata[15:0], 16'h0040);
        bus(0, A_STAT2, 0);
        chk("stat2", rdata[15:0], 16'h0000);
        bus(1, A_STAT1, 16'hFFFF);
        bus(0, A_STAT1, 0);
        chk("stat1 kept", rdata[15:0], 16'h0040);
        bus(0, 6'h24, 0);
        chk("unmapped", rdata[15:0], 16'h0000);
        $display("test reset done");
        bus(1, A_CONFIG, 16'h0002);
        fast <= 1'b1;
        run <= 1'b1;
        repeat (40) @(posedge clk_i);
        run <= 1'b0;
        bus(0, A_INFO, 0);
        chk("too fast", 16'(rdata[8]), 16'h0001);
        bus(1, A_INFO, 16'h0100);
        bus(0, A_INFO, 0);
        chk("too fast clear", 16'(rdata[8]), 16'h0000);
        $display("test cycle period done");
        st = ST_INHIBITED;
        bus(1, A_PERIOD, 16'h0028);
        fast <= 1'b0;
        run <= 1'b1;
        do @(posedge clk_i); while (tk !== 1'b1);
        for (int i = 0; i < 76; i++)
        begin
            r = rnd();
            c = i < 16 ? corner[i] : {r[3], |r[7:6], |r[5:4], r[0]};
            d = i >= 16 && r[9:8] == 2'b11;
            p = rnd();
            b = rnd();
            m = rnd();
            bus(1, A_CTRL, {r[15:4], c});
            bus(1, A_POSCTL, p);
            bus(1, A_BLKSEL, b);
            bus(1, A_MDIMOD, m);
            bus(1, A_CONFIG, {14'h0000, r[11], r[10]});
            dd <= d;
            do @(posedge clk_i); while (tk !== 1'b1);
            st = nxt(st, c, d);
            ed = r[10] ? b[15] : p[15];
            ea = r[10] ? 1'b0 : p[14];
            eb = r[10] ? m[0] : p[8];
            chk("status one", s1, sw1(st));
            chk("status two", s2, st inside {ST_OPERATION, ST_RAMP_STOP, ST_QUICK_STOP}
                ? 16'h0800 : 16'h0000);
            chk("levels", 16'({tq, rs, qs}),
                16'({st == ST_OPERATION, st == ST_RAMP_STOP, st == ST_QUICK_STOP}));
            chk("mode", 16'({ab, am, dm}), 16'({eb, ea, ed}));
            bus(0, A_INFO, 0);
            chk("info", 16'(rdata[6:0]), 16'({eb, ea, ed, 1'b0, st}));
        end
        $display("test state sequence done");
        wrap_up();
    end
endmodule : dcs_drive_ctrl_tb_top

bind dcs_drive_ctrl dcs_drive_ctrl_props i_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .drive_status_word_one_o(drive_status_word_one_o),
    .drive_status_word_two_o(drive_status_word_two_o), .torque_enable_o(torque_enable_o),
    .ramp_stop_o(ramp_stop_o), .quick_stop_o(quick_stop_o), .eval_tick_o(eval_tick_o));
